// file: rtl/adc_seq_ctrl.sv
// What this block does
// - a 32-bit read/write step control register, all fields reset to zero
// - step n uses bits 4n..4n+3: diff, last, irq enable, temp
// - temp select set converts the sensor, else the selected input pin
// - irq enable set raises the raw interrupt when that step finishes
// - raw interrupt reaches the interrupt output only while its mask is set
// - any number of steps may raise the raw interrupt
// - the step flagged last ends the sequence, at any position
// - steps after the first last flag are never requested
// - single-step variant holds the first step's last flag set
// - differential step samples pair 2i and 2i+1 for select value i
// - single-ended step converts the pin numbered by its select field
// - a trigger starts only if the sequencer is active, else ignored
`timescale 1ns/1ns
module adc_seq_ctrl
    import adc_seq_pkg::*;
#(
    parameter bit SINGLE_STEP = 1'b0
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic conv_start,
    output logic conv_temp,
    output logic conv_diff,
    output logic [MUX_W-1:0] conv_input,
    output logic [IDX_W-1:0] conv_step,
    input wire logic conv_done,
    output logic irq
);

    logic [31:0] step_control;
    logic [31:0] input_select;
    logic active;
    logic [STATUS_W-1:0] raw_status;
    logic [STATUS_W-1:0] irq_mask;
    seq_state_t state;
    seq_state_t next_state;
    logic [IDX_W-1:0] step_idx;
    logic [IDX_W-1:0] next_idx;

    step_cfg_if cfg();

    step_decoder u_dec (
        .cfg(cfg.dec)
    );

    // ****************************************************************
    // bus decode
    // ****************************************************************
    wire bus_take = ce & wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire bus_wr = bus_take & wb_we_i;
    wire bus_rd = bus_take & ~wb_we_i;
    wire hit_ctl = wb_adr_i == STEP_CONTROL_OFS;
    wire hit_mux = wb_adr_i == INPUT_SELECT_OFS;
    wire hit_act = wb_adr_i == ACTIVE_OFS;
    wire hit_stat = wb_adr_i == RAW_STATUS_OFS;
    wire hit_mask = wb_adr_i == IRQ_MASK_OFS;
    wire hit_seq = wb_adr_i == SEQ_STATE_OFS;
    wire hit_trig = wb_adr_i == TRIGGER_OFS;

    // single-step variant cannot clear the first step's last flag
    wire [31:0] ctl_eff = SINGLE_STEP ?
        (step_control | FIRST_STEP_LAST) : step_control;

    assign cfg.ctl = ctl_eff;
    assign cfg.mux = input_select;
    assign cfg.idx = step_idx;

    // ****************************************************************
    // sequencing events
    // ****************************************************************
    wire trig_write = bus_wr & hit_trig & wb_sel_i[0] &
        wb_dat_i[TRIGGER_SEQ0];
    // trigger while inactive or busy has no effect
    wire trig_ok = trig_write & active &
        (state == SEQ_IDLE);
    wire conv_finish = ce & (state == SEQ_WAIT) & conv_done;
    // without any last flag the run stops after the eighth step
    wire seq_end = conv_finish &
        (cfg.cur_last | (step_idx == LAST_IDX));
    wire raw_set = conv_finish & cfg.cur_ie;

    // ****************************************************************
    // interrupt status: hardware set wins over a write-one clear
    // ****************************************************************
    wire [STATUS_W-1:0] status_set;
    wire [STATUS_W-1:0] status_clr;
    assign status_set[ST_RAW_IRQ] = raw_set;
    assign status_set[ST_SEQ_DONE] = seq_end;
    assign status_clr = (bus_wr & hit_stat & wb_sel_i[0]) ?
        wb_dat_i[STATUS_W-1:0] : STATUS_RESET;
    assign irq = |(raw_status & irq_mask);

    // ****************************************************************
    // read selection
    // ****************************************************************
    wire [31:0] seq_word = {24'h00_0000, 1'b0, step_idx, 3'h0,
        state != SEQ_IDLE};
    wire [31:0] read_word =
        hit_ctl ? ctl_eff :
        hit_mux ? input_select :
        hit_act ? {31'h0000_0000, active} :
        hit_stat ? {30'h0000_0000, raw_status} :
        hit_mask ? {30'h0000_0000, irq_mask} :
        hit_seq ? seq_word :
        ZERO_WORD;

    // ****************************************************************
    // registers
    // ****************************************************************
    // every field starts at zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            step_control <= CTL_RESET;
        end else if (bus_wr && hit_ctl) begin
            step_control <= byte_merge(step_control, wb_dat_i,
                wb_sel_i);
        end
    end

    // reserved select bits read back as zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            input_select <= MUX_RESET;
        end else if (bus_wr && hit_mux) begin
            input_select <= byte_merge(input_select, wb_dat_i,
                wb_sel_i) & MUX_RW_MASK;
        end
    end

    // active flag and interrupt mask live in byte lane 0
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            active <= 1'b0;
            irq_mask <= STATUS_RESET;
        end else if (bus_wr && wb_sel_i[0]) begin
            if (hit_act) begin
                active <= wb_dat_i[ACTIVE_SEQ0];
            end
            if (hit_mask) begin
                irq_mask <= wb_dat_i[STATUS_W-1:0];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            raw_status <= STATUS_RESET;
        end else if (ce) begin
            raw_status <= (raw_status & ~status_clr) | status_set;
        end
    end

    // ack one cycle after the request; dropped the cycle after
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= ZERO_WORD;
        end else if (ce) begin
            wb_ack_o <= bus_take;
            if (bus_rd) begin
                wb_dat_o <= read_word;
            end
        end
    end

    // ****************************************************************
    // step sequencer
    // ****************************************************************
    always_comb begin
        next_state = state;
        next_idx = step_idx;
        case (state)
            SEQ_IDLE: begin
                if (trig_ok) begin
                    next_state = SEQ_START;
                    next_idx = FIRST_IDX;
                end
            end
            SEQ_START: begin
                next_state = SEQ_WAIT;
            end
            SEQ_WAIT: begin
                if (seq_end) begin
                    next_state = SEQ_IDLE;
                end else if (conv_finish) begin
                    next_state = SEQ_START;
                    next_idx = step_idx + IDX_ONE;
                end
            end
            default: begin
                next_state = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= SEQ_IDLE;
            step_idx <= FIRST_IDX;
        end else if (ce) begin
            state <= next_state;
            step_idx <= next_idx;
        end
    end

    // request and step fields leave together from flops
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            conv_start <= 1'b0;
            conv_temp <= 1'b0;
            conv_diff <= 1'b0;
            conv_input <= '0;
            conv_step <= FIRST_IDX;
        end else if (ce) begin
            conv_start <= state == SEQ_START;
            if (state == SEQ_START) begin
                conv_temp <= cfg.cur_temp;
                conv_diff <= cfg.cur_diff;
                conv_input <= cfg.cur_input;
                conv_step <= step_idx;
            end
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    sequence s_full_ctl_write;
        bus_wr && hit_ctl && (wb_sel_i == 4'hF);
    endsequence
    property p_ctl_write;
        s_full_ctl_write |=> step_control == $past(wb_dat_i);
    endproperty
    a_ctl_write: assert property (p_ctl_write)
        else $error("step control write not stored");
    property p_field_temp;
        (ce && state == SEQ_START) |=> conv_start &&
            conv_temp == $past(step_control[int'(step_idx) * NIB_W +
            TEMP_BIT]);
    endproperty
    a_field_temp: assert property (p_field_temp)
        else $error("temperature select taken from wrong bit");
    property p_temp_source;
        (ce && state == SEQ_START && cfg.cur_temp) |=> conv_temp;
    endproperty
    a_temp_source: assert property (p_temp_source)
        else $error("temperature step not sent to sensor");
    property p_raw_set;
        (conv_finish && cfg.cur_ie) |=> raw_status[ST_RAW_IRQ];
    endproperty
    a_raw_set: assert property (p_raw_set)
        else $error("raw interrupt not raised after enabled step");
    property p_raw_quiet;
        (ce && !raw_status[ST_RAW_IRQ] && !(conv_finish && cfg.cur_ie))
            |=> !raw_status[ST_RAW_IRQ];
    endproperty
    a_raw_quiet: assert property (p_raw_quiet)
        else $error("raw interrupt raised without enabled step");
    property p_irq_gate;
        (raw_status[ST_RAW_IRQ] && !irq_mask[ST_RAW_IRQ] &&
            !(raw_status[ST_SEQ_DONE] && irq_mask[ST_SEQ_DONE])) |-> !irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("masked raw interrupt reached the output");
    property p_irq_pass;
        (raw_status[ST_RAW_IRQ] && irq_mask[ST_RAW_IRQ]) |-> irq;
    endproperty
    a_irq_pass: assert property (p_irq_pass)
        else $error("unmasked raw interrupt did not reach the output");
    property p_irq_masked;
        (irq_mask == STATUS_RESET) |-> !irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("interrupt output high while fully masked");
    property p_multi_irq;
        (conv_finish && cfg.cur_ie && !seq_end) |=> ##1 conv_start;
    endproperty
    a_multi_irq: assert property (p_multi_irq)
        else $error("sequence did not continue after irq step");
    sequence s_last_done;
        conv_finish && cfg.cur_last;
    endsequence
    property p_last_stops;
        s_last_done |=> state == SEQ_IDLE ##1 !conv_start;
    endproperty
    a_last_stops: assert property (p_last_stops)
        else $error("sequence ran past the last step");
    property p_valid_only;
        (ce && state == SEQ_START) |-> cfg.valid_mask[step_idx];
    endproperty
    a_valid_only: assert property (p_valid_only)
        else $error("step after the last flag requested");
    property p_single;
        SINGLE_STEP |-> ctl_eff[LAST_BIT];
    endproperty
    a_single: assert property (p_single)
        else $error("single-step last flag not held");
    property p_diff_pair;
        (ce && state == SEQ_START) |=> conv_diff == $past(cfg.cur_diff)
            && conv_input == $past(mux_field(input_select, step_idx));
    endproperty
    a_diff_pair: assert property (p_diff_pair)
        else $error("pair or pin index not forwarded");
    property p_trig_ignored;
        (trig_write && !active && state == SEQ_IDLE) |=>
            state == SEQ_IDLE [*2];
    endproperty
    a_trig_ignored: assert property (p_trig_ignored)
        else $error("inactive sequencer started");
    sequence s_trig_start;
        trig_ok ##1 (state == SEQ_START && step_idx == FIRST_IDX);
    endsequence
    property p_start_zero;
        trig_ok |-> s_trig_start ##1 (conv_start && conv_step == FIRST_IDX);
    endproperty
    a_start_zero: assert property (p_start_zero)
        else $error("sequence did not start at step zero");
    property p_ascend;
        (conv_finish && !seq_end) |=> step_idx == $past(step_idx) + IDX_ONE;
    endproperty
    a_ascend: assert property (p_ascend)
        else $error("steps not taken in ascending order");

endmodule // adc_seq_ctrl

// file: rtl/adc_seq_pkg.sv
package adc_seq_pkg;

    // ****************************************************************
    // geometry
    // ****************************************************************
    localparam int STEPS = 8;
    localparam int NIB_W = 4;
    localparam int MUX_W = 2;
    localparam int IDX_W = 3;
    localparam int STATUS_W = 2;
    localparam logic [IDX_W-1:0] FIRST_IDX = 3'h0;
    localparam logic [IDX_W-1:0] LAST_IDX = 3'h7;
    localparam logic [IDX_W-1:0] IDX_ONE = 3'h1;

    // ****************************************************************
    // register byte addresses
    // ****************************************************************
    localparam logic [7:0] ACTIVE_OFS = 8'h00;
    localparam logic [7:0] RAW_STATUS_OFS = 8'h04;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h08;
    localparam logic [7:0] SEQ_STATE_OFS = 8'h0C;
    localparam logic [7:0] TRIGGER_OFS = 8'h28;
    localparam logic [7:0] INPUT_SELECT_OFS = 8'h40;
    localparam logic [7:0] STEP_CONTROL_OFS = 8'h44;

    // ****************************************************************
    // field positions inside a step nibble and other registers
    // ****************************************************************
    localparam int DIFF_BIT = 0;
    localparam int LAST_BIT = 1;
    localparam int IE_BIT = 2;
    localparam int TEMP_BIT = 3;
    localparam int ST_RAW_IRQ = 0;
    localparam int ST_SEQ_DONE = 1;
    localparam int ACTIVE_SEQ0 = 0;
    localparam int TRIGGER_SEQ0 = 0;
    localparam int STATE_BUSY_BIT = 0;
    localparam int STATE_IDX_LSB = 4;

    // ****************************************************************
    // reset values and masks
    // ****************************************************************
    localparam logic [31:0] CTL_RESET = 32'h0000_0000;
    localparam logic [31:0] MUX_RESET = 32'h0000_0000;
    localparam logic [31:0] MUX_RW_MASK = 32'h3333_3333;
    localparam logic [31:0] FIRST_STEP_LAST = 32'h0000_0002;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [STATUS_W-1:0] STATUS_RESET = 2'h0;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_START, SEQ_WAIT} seq_state_t;

    // nibble of one step
    function automatic logic [NIB_W-1:0] step_nibble(
        input logic [31:0] ctl, input logic [IDX_W-1:0] idx);
        return ctl[int'(idx) * NIB_W +: NIB_W];
    endfunction

    // input select field of one step
    function automatic logic [MUX_W-1:0] mux_field(
        input logic [31:0] mux, input logic [IDX_W-1:0] idx);
        return mux[int'(idx) * NIB_W +: MUX_W];
    endfunction

    // byte-lane write merge for a bus word
    function automatic logic [31:0] byte_merge(input logic [31:0] old,
        input logic [31:0] wdat, input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = wdat[b*8 +: 8];
            end
        end
        return res;
    endfunction

endpackage

// file: rtl/step_cfg_if.sv
`timescale 1ns/1ns
interface step_cfg_if;
    import adc_seq_pkg::*;
    logic [31:0] ctl;
    logic [31:0] mux;
    logic [IDX_W-1:0] idx;
    logic [STEPS-1:0] valid_mask;
    logic cur_temp;
    logic cur_ie;
    logic cur_last;
    logic cur_diff;
    logic [MUX_W-1:0] cur_input;

    modport ctrl(output ctl, output mux, output idx, input valid_mask,
        input cur_temp, input cur_ie, input cur_last, input cur_diff,
        input cur_input);
    modport dec(input ctl, input mux, input idx, output valid_mask,
        output cur_temp, output cur_ie, output cur_last, output cur_diff,
        output cur_input);
endinterface

// file: rtl/step_decoder.sv
`timescale 1ns/1ns
module step_decoder
    import adc_seq_pkg::*;
(
    step_cfg_if.dec cfg
);

    logic [NIB_W-1:0] cur_nib;
    logic [STEPS-1:0] valid_bits;

    // ****************************************************************
    // steps that may be requested: none after the first marked last
    // ****************************************************************
    // a local vector keeps the interface signal to a single driver
    assign valid_bits[0] = 1'b1;
    for (genvar n = 1; n < STEPS; n++) begin : g_valid
        wire [NIB_W-1:0] prev_nib = step_nibble(cfg.ctl, IDX_W'(n - 1));
        assign valid_bits[n] = valid_bits[n-1] &
            ~prev_nib[LAST_BIT];
    end
    assign cfg.valid_mask = valid_bits;

    // ****************************************************************
    // fields of the step now in progress
    // ****************************************************************
    assign cur_nib = step_nibble(cfg.ctl, cfg.idx);
    assign cfg.cur_temp = cur_nib[TEMP_BIT];
    assign cfg.cur_ie = cur_nib[IE_BIT];
    assign cfg.cur_last = cur_nib[LAST_BIT];
    assign cfg.cur_diff = cur_nib[DIFF_BIT];
    // single-ended: pin number; differential: pair index
    assign cfg.cur_input = mux_field(cfg.mux, cfg.idx);

endmodule // step_decoder

// file: testbench/tb_adc_seq_ctrl.sv
`timescale 1ns/1ns
module tb_adc_seq_ctrl;
    import adc_seq_pkg::*;

    // ****************************************************************
    // signals
    // ****************************************************************
    typedef struct packed {
        logic temp;
        logic diff;
        logic [MUX_W-1:0] pin;
        logic [IDX_W-1:0] step;
    } conv_exp_t;

    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o, wb_dat_o2;
    logic wb_ack_o, conv_start, conv_start2, conv_temp, conv_diff, irq;
    logic [MUX_W-1:0] conv_input;
    logic [IDX_W-1:0] conv_step;
    logic conv_done = 1'b0;
    logic [2:0] done_wait = 3'h0;
    logic [31:0] rd_q[$];
    conv_exp_t cv_q[$];
    logic [31:0] exp_word;
    conv_exp_t exp_conv;
    conv_exp_t seen_conv;
    int fail_count = 0;
    int n_compared = 0;
    int n_starts = 0;
    int n_starts2 = 0;
    int cycles = 0;
    integer seed = 56;

    always #4 mclk = ~mclk;

    adc_seq_ctrl dut (.mclk(mclk), .rst_n(rst_n), .ce(ce),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conv_start(conv_start),
        .conv_temp(conv_temp), .conv_diff(conv_diff),
        .conv_input(conv_input), .conv_step(conv_step),
        .conv_done(conv_done), .irq(irq));

    // single-step variant shares the bus; only its reads and starts are used
    adc_seq_ctrl #(.SINGLE_STEP(1'b1)) dut2 (.mclk(mclk), .rst_n(rst_n),
        .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o2), .wb_ack_o(),
        .conv_start(conv_start2), .conv_temp(), .conv_diff(),
        .conv_input(), .conv_step(), .conv_done(conv_done), .irq());

    // ****************************************************************
    // reporting and comparison
    // ****************************************************************
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic mismatch(input string msg);
        fail_count++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) mismatch($sformatf("read %h want %h", got, exp));
    endtask

    task automatic cmp_conv(input conv_exp_t got, input conv_exp_t exp);
        n_compared++;
        if (got !== exp) mismatch($sformatf("start %h want %h", got, exp));
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) mismatch("output level wrong");
    endtask

    // ****************************************************************
    // bus master: request held until ack is sampled, then released
    // ****************************************************************
    task automatic bus(input logic we, input logic [7:0] adr,
        input logic [31:0] dat, input logic [3:0] sel);
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel;
        do @(posedge mclk); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        bus(1'b1, adr, dat, 4'hF);
    endtask

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        rd_q.push_back(exp);
        bus(1'b0, adr, 32'h0000_0000, 4'hF);
    endtask

    // ****************************************************************
    // watchers: oldest note is compared whenever a result appears
    // ****************************************************************
    // fields of the current start, packed in the order of a note
    assign seen_conv = {conv_temp, conv_diff, conv_input, conv_step};

    always @(posedge mclk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            if (rd_q.size() == 0) begin
                mismatch("read answer without request");
            end else begin
                exp_word = rd_q.pop_front();
                cmp_word(wb_dat_o, exp_word);
                if (wb_adr_i == STEP_CONTROL_OFS) begin
                    cmp_word(wb_dat_o2, exp_word | FIRST_STEP_LAST);
                end
            end
        end
        if (conv_start2 === 1'b1) n_starts2++;
        if (conv_start === 1'b1) begin
            n_starts++;
            if (cv_q.size() == 0) begin
                mismatch("conversion start not expected");
            end else begin
                exp_conv = cv_q.pop_front();
                cmp_conv(seen_conv, exp_conv);
            end
        end
    end

    // converter stand-in: finishes each request after 1..4 cycles
    always @(posedge mclk) begin
        conv_done <= (done_wait == 3'h1) && (conv_start !== 1'b1);
        if (conv_start === 1'b1) begin
            done_wait <= 3'h1 + 3'($unsigned($random(seed)) % 4);
        end else if (done_wait != 3'h0) begin
            done_wait <= done_wait - 3'h1;
        end
    end

    // hang guard sized well above the expected run length
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatch("timeout");
            complete_run();
        end
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin : main_seq
        logic [31:0] ctl, mux, dat;
        logic [3:0] sel;
        logic any_ie;
        int k, target, base2;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        rd(STEP_CONTROL_OFS, CTL_RESET);
        rd(INPUT_SELECT_OFS, MUX_RESET);
        rd(RAW_STATUS_OFS, ZERO_WORD);
        // byte lanes only touch the fields they enable
        dat = $random(seed);
        sel = 4'($random(seed));
        ctl = ZERO_WORD;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) ctl[b*8 +: 8] = dat[b*8 +: 8];
        end
        bus(1'b1, STEP_CONTROL_OFS, dat, sel);
        rd(STEP_CONTROL_OFS, ctl);
        wr(8'h80, 32'hFFFF_FFFF);
        rd(8'h80, ZERO_WORD);
        // a frozen block leaves the request unanswered until enable returns
        dat = $random(seed);
        ce <= 1'b0;
        fork
            wr(STEP_CONTROL_OFS, dat);
            begin
                repeat (6) begin
                    @(posedge mclk);
                    cmp_bit(wb_ack_o, 1'b0);
                end
                ce <= 1'b1;
            end
        join
        rd(STEP_CONTROL_OFS, dat);
        // a trigger on an inactive sequencer starts nothing
        bus(1'b1, TRIGGER_OFS, 32'h0000_0001, 4'h1);
        repeat (8) @(posedge mclk);
        wr(ACTIVE_OFS, 32'h0000_0001);
        rd(ACTIVE_OFS, 32'h0000_0001);
        for (int r = 0; r < 12; r++) begin
            k = (r == 0) ? 0 : (r == 1) ? 7 : $unsigned($random(seed)) % 8;
            ctl = $random(seed);
            mux = $random(seed);
            for (int i = 0; i < STEPS; i++) begin
                if (ctl[4*i+3]) ctl[4*i] = 1'b0;
                if (i < k) ctl[4*i+1] = 1'b0;
            end
            ctl[4*k+1] = 1'b1;
            wr(STEP_CONTROL_OFS, ctl);
            rd(STEP_CONTROL_OFS, ctl);
            wr(INPUT_SELECT_OFS, mux);
            rd(INPUT_SELECT_OFS, mux & MUX_RW_MASK);
            // steps beyond the first last flag must never be requested
            any_ie = 1'b0;
            for (int i = 0; i <= k; i++) begin
                cv_q.push_back({ctl[4*i+3], ctl[4*i], mux[4*i +: 2],
                    IDX_W'(i)});
                any_ie = any_ie | ctl[4*i+2];
            end
            target = n_starts + k + 1;
            base2 = n_starts2;
            bus(1'b1, TRIGGER_OFS, 32'h0000_0001, 4'h1);
            // a second trigger while busy is dropped
            bus(1'b1, TRIGGER_OFS, 32'h0000_0001, 4'h1);
            wait (n_starts == target);
            repeat (12) @(posedge mclk);
            cmp_word(32'(n_starts2 - base2), 32'h0000_0001);
            cmp_bit(irq, 1'b0);
            // idle again, parked on the step that carried the last flag
            rd(SEQ_STATE_OFS, 32'(k) << STATE_IDX_LSB);
            rd(RAW_STATUS_OFS, {30'h0, 1'b1, any_ie});
            wr(IRQ_MASK_OFS, 32'h0000_0001);
            rd(IRQ_MASK_OFS, 32'h0000_0001);
            @(posedge mclk);
            cmp_bit(irq, any_ie);
            wr(RAW_STATUS_OFS, 32'h0000_0003);
            rd(RAW_STATUS_OFS, ZERO_WORD);
            @(posedge mclk);
            cmp_bit(irq, 1'b0);
            wr(IRQ_MASK_OFS, ZERO_WORD);
        end
        repeat (4) @(posedge mclk);
        if (cv_q.size() != 0 || rd_q.size() != 0) mismatch("results missing");
        complete_run();
    end

endmodule // tb_adc_seq_ctrl
